// *** src/segment_shared_io_ports.sv ***
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - first port direction register: 8 bits, 1 makes output, 0 makes input
// - first port direction and latch act only where segment-select gives pin to gpio
// - first port direction clears to zero on reset, all pins inputs
// - first port direction is write-only, reads back all ones
// - upper pins 7..4: gpio on 00xx, segment n+17 on 01xx or 1xxx
// - lower pins 3..0: gpio on 00xx or 0100, segment on 0101, 011x, 1xxx
// - first port pins float in reset and standby, hold in sleep, subsleep, watch
// - second port is an 8-bit bidirectional general purpose port
// - second port data latch at index ffdb, read/write, resets to zero
// - second port direction at index ffeb, write-only, resets to zero
// - second port data read: output bits give latch, input bits give pin
// - second port data latch resets to zero
// - first port data latch at index ffda, direction at ffea, both reset zero
// - first port data read: output bits give latch, input bits give pin
// - second port direction: 1 output, 0 input, write-only, reads all ones
module segment_shared_io_ports #(
  parameter int ADDR_W = 18,
  parameter int PORT_W = 8
) (
  input wire logic clk_i, // 250 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [ADDR_W-1:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic [PORT_W-1:0] lcd_segment_output_i, // segments 17..24 from lcd driver
  input wire logic [PORT_W-1:0] port_a_pin_i, // first port pin levels
  output logic [PORT_W-1:0] port_a_pin_o, // first port pin drive value
  output logic [PORT_W-1:0] port_a_pin_oe_o, // first port pin drive enable
  input wire logic [PORT_W-1:0] port_b_pin_i, // second port pin levels
  output logic [PORT_W-1:0] port_b_pin_o, // second port pin drive value
  output logic [PORT_W-1:0] port_b_pin_oe_o // second port pin drive enable
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic idx_hit(input logic [ADDR_W-1:0] adr, input logic [15:0] idx);
    idx_hit = (adr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  // true when pin n of the first port is general i/o for this select code
  function automatic logic a_is_gpio(input logic [3:0] seg_sel, input int n);
    logic upper_gpio;
    upper_gpio = (seg_sel[3:2] == 2'b00);
    if (n >= PORT_W / 2) begin
      a_is_gpio = upper_gpio;
    end else begin
      a_is_gpio = upper_gpio || (seg_sel == seg_io_pkg::SEG_SEL_LOW_GPIO_EXTRA);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [PORT_W-1:0] a_latch_r, a_latch_nxt;
  logic [PORT_W-1:0] a_dir_r, a_dir_nxt;
  logic [PORT_W-1:0] b_latch_r, b_latch_nxt;
  logic [PORT_W-1:0] b_dir_r, b_dir_nxt;
  logic [3:0] seg_sel_r, seg_sel_nxt;
  seg_io_pkg::op_mode_e mode_r, mode_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req;
  logic wr_lane0;

  assign req = cyc_i && stb_i && !ack_r;
  assign wr_lane0 = req && we_i && sel_i[0];

  always_comb begin
    a_latch_nxt = a_latch_r;
    a_dir_nxt = a_dir_r;
    b_latch_nxt = b_latch_r;
    b_dir_nxt = b_dir_r;
    seg_sel_nxt = seg_sel_r;
    mode_nxt = mode_r;
    ack_nxt = req;
    rdata_nxt = rdata_r;
    if (wr_lane0) begin
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DATA_LATCH)) begin
        a_latch_nxt = dat_i[PORT_W-1:0];
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DIRECTION)) begin
        a_dir_nxt = dat_i[PORT_W-1:0];
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DATA_LATCH)) begin
        b_latch_nxt = dat_i[PORT_W-1:0];
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DIRECTION)) begin
        b_dir_nxt = dat_i[PORT_W-1:0];
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_LCD_PORT_CONTROL)) begin
        seg_sel_nxt = dat_i[seg_io_pkg::SEG_SEL_LSB +: seg_io_pkg::SEG_SEL_W];
      end
      // an undefined mode code is ignored, the old mode stays
      if (idx_hit(adr_i, seg_io_pkg::IDX_OP_MODE)) begin
        unique case (dat_i[seg_io_pkg::OP_MODE_LSB +: seg_io_pkg::OP_MODE_W])
          3'h0: mode_nxt = seg_io_pkg::MODE_ACTIVE;
          3'h1: mode_nxt = seg_io_pkg::MODE_SUBACTIVE;
          3'h2: mode_nxt = seg_io_pkg::MODE_SLEEP;
          3'h3: mode_nxt = seg_io_pkg::MODE_SUBSLEEP;
          3'h4: mode_nxt = seg_io_pkg::MODE_WATCH;
          3'h5: mode_nxt = seg_io_pkg::MODE_STANDBY;
          default: mode_nxt = mode_r;
        endcase
      end
    end
    if (req && !we_i) begin
      rdata_nxt = seg_io_pkg::UNMAPPED_READ;
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DATA_LATCH)) begin
        rdata_nxt[PORT_W-1:0] = (a_dir_r & a_latch_r) | (~a_dir_r & port_a_pin_i);
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DATA_LATCH)) begin
        rdata_nxt[PORT_W-1:0] = (b_dir_r & b_latch_r) | (~b_dir_r & port_b_pin_i);
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DIRECTION)) begin
        rdata_nxt[PORT_W-1:0] = seg_io_pkg::DIRECTION_READ;
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DIRECTION)) begin
        rdata_nxt[PORT_W-1:0] = seg_io_pkg::DIRECTION_READ;
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_LCD_PORT_CONTROL)) begin
        rdata_nxt[seg_io_pkg::SEG_SEL_LSB +: seg_io_pkg::SEG_SEL_W] = seg_sel_r;
      end
      if (idx_hit(adr_i, seg_io_pkg::IDX_OP_MODE)) begin
        rdata_nxt[seg_io_pkg::OP_MODE_LSB +: seg_io_pkg::OP_MODE_W] = mode_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_latch_r <= seg_io_pkg::DATA_LATCH_RST;
      a_dir_r <= seg_io_pkg::DIRECTION_RST;
      b_latch_r <= seg_io_pkg::DATA_LATCH_RST;
      b_dir_r <= seg_io_pkg::DIRECTION_RST;
      seg_sel_r <= seg_io_pkg::SEG_SEL_RST;
      mode_r <= seg_io_pkg::OP_MODE_RST;
      ack_r <= 1'b0;
      rdata_r <= seg_io_pkg::UNMAPPED_READ;
    end else begin
      a_latch_r <= a_latch_nxt;
      a_dir_r <= a_dir_nxt;
      b_latch_r <= b_latch_nxt;
      b_dir_r <= b_dir_nxt;
      seg_sel_r <= seg_sel_nxt;
      mode_r <= mode_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  logic [PORT_W-1:0] a_o_r, a_o_nxt, a_oe_r, a_oe_nxt;
  logic [PORT_W-1:0] b_o_r, b_o_nxt, b_oe_r, b_oe_nxt;
  logic [PORT_W-1:0] a_fn_o, a_fn_oe;
  logic functional, holding;

  assign functional = (mode_r == seg_io_pkg::MODE_ACTIVE) || (mode_r == seg_io_pkg::MODE_SUBACTIVE);
  assign holding = (mode_r == seg_io_pkg::MODE_SLEEP) || (mode_r == seg_io_pkg::MODE_SUBSLEEP)
                   || (mode_r == seg_io_pkg::MODE_WATCH);

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_a_pin
      always_comb begin
        if (a_is_gpio(seg_sel_r, gi)) begin
          a_fn_o[gi] = a_dir_r[gi] & a_latch_r[gi];
          a_fn_oe[gi] = a_dir_r[gi];
        end else begin
          a_fn_o[gi] = lcd_segment_output_i[gi];
          a_fn_oe[gi] = 1'b1;
        end
      end
    end
  endgenerate

  always_comb begin
    a_o_nxt = a_o_r;
    a_oe_nxt = a_oe_r;
    if (functional) begin
      a_o_nxt = a_fn_o;
      a_oe_nxt = a_fn_oe;
    end else if (!holding) begin
      a_o_nxt = '0;
      a_oe_nxt = '0;
    end
    b_o_nxt = b_dir_r & b_latch_r;
    b_oe_nxt = b_dir_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_o_r <= '0;
      a_oe_r <= '0;
      b_o_r <= '0;
      b_oe_r <= '0;
    end else begin
      a_o_r <= a_o_nxt;
      a_oe_r <= a_oe_nxt;
      b_o_r <= b_o_nxt;
      b_oe_r <= b_oe_nxt;
    end
  end

  assign port_a_pin_o = a_o_r;
  assign port_a_pin_oe_o = a_oe_r;
  assign port_b_pin_o = b_o_r;
  assign port_b_pin_oe_o = b_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic rd_a_dir, rd_b_data;
  assign rd_a_dir = req && !we_i && idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DIRECTION);
  assign rd_b_data = req && !we_i && idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DATA_LATCH);
  logic rd_a_data, rd_b_dir, wr_a_data, wr_a_dir, wr_b_data, wr_b_dir;
  assign rd_a_data = req && !we_i && idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DATA_LATCH);
  assign rd_b_dir = req && !we_i && idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DIRECTION);
  assign wr_a_data = wr_lane0 && idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DATA_LATCH);
  assign wr_a_dir = wr_lane0 && idx_hit(adr_i, seg_io_pkg::IDX_PORT_A_DIRECTION);
  assign wr_b_data = wr_lane0 && idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DATA_LATCH);
  assign wr_b_dir = wr_lane0 && idx_hit(adr_i, seg_io_pkg::IDX_PORT_B_DIRECTION);

  dir_readback_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_a_dir |=> ack_o && dat_o == 32'h0000_00ff)
    else $error("direction readback not all ones");

  dir_reset_a: assert property (
    @(posedge clk_i) rst_i |=> a_dir_r == 8'h00 && b_dir_r == 8'h00)
    else $error("direction not cleared by reset");

  latch_reset_a: assert property (
    @(posedge clk_i) rst_i |=> b_latch_r == 8'h00 && a_latch_r == 8'h00)
    else $error("latch not cleared by reset");

  reset_float_a: assert property (
    @(posedge clk_i) rst_i |=> port_a_pin_oe_o == 8'h00)
    else $error("first port driven during reset");

  standby_float_a: assert property (
    @(posedge clk_i) disable iff (rst_i) mode_r == seg_io_pkg::MODE_STANDBY |=> port_a_pin_oe_o == 8'h00)
    else $error("first port driven in standby");

  sleep_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i) holding ##1 holding |-> $stable(port_a_pin_o) && $stable(port_a_pin_oe_o))
    else $error("first port changed while held");

  gpio_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i) functional && seg_sel_r == 4'h0
    |=> port_a_pin_oe_o == $past(a_dir_r) && port_a_pin_o == ($past(a_dir_r) & $past(a_latch_r)))
    else $error("gpio pin drive mismatch");

  seg_select_a: assert property (
    @(posedge clk_i) disable iff (rst_i) functional && seg_sel_r[3]
    |=> port_a_pin_oe_o == 8'hff && port_a_pin_o == $past(lcd_segment_output_i))
    else $error("segment takeover mismatch");

  low_gpio_a: assert property (
    @(posedge clk_i) disable iff (rst_i) functional && seg_sel_r == 4'h4
    |=> port_a_pin_oe_o[7:4] == 4'hf && port_a_pin_oe_o[3:0] == $past(a_dir_r[3:0]))
    else $error("code 0100 split wrong");

  b_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_b_data
    |=> dat_o[7:0] == (($past(b_dir_r) & $past(b_latch_r)) | (~$past(b_dir_r) & $past(port_b_pin_i))))
    else $error("second port read mix wrong");

  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_timing_a: assert property (
    @(posedge clk_i) disable iff (rst_i) req |=> ack_o)
    else $error("request not answered in one cycle");

  dir_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i) wr_a_dir |=> a_dir_r == $past(dat_i[PORT_W-1:0]))
    else $error("first port direction write lost");

  a_data_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i) wr_a_data |=> a_latch_r == $past(dat_i[PORT_W-1:0]))
    else $error("first port latch write lost");

  b_data_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i) wr_b_data |=> b_latch_r == $past(dat_i[PORT_W-1:0]))
    else $error("second port latch write lost");

  b_dir_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i) wr_b_dir |=> b_dir_r == $past(dat_i[PORT_W-1:0]))
    else $error("second port direction write lost");

  b_dir_readback_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_b_dir |=> ack_o && dat_o == 32'h0000_00ff)
    else $error("second direction readback not all ones");

  a_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_a_data
    |=> dat_o[7:0] == (($past(a_dir_r) & $past(a_latch_r)) | (~$past(a_dir_r) & $past(port_a_pin_i))))
    else $error("first port read mix wrong");

  b_pin_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i) 1'b1
    |=> port_b_pin_oe_o == $past(b_dir_r) && port_b_pin_o == ($past(b_dir_r) & $past(b_latch_r)))
    else $error("second port pin drive mismatch");

  upper_seg_a: assert property (
    @(posedge clk_i) disable iff (rst_i) functional && seg_sel_r[3:2] == 2'b01
    |=> port_a_pin_oe_o[7:4] == 4'hf && port_a_pin_o[7:4] == $past(lcd_segment_output_i[7:4]))
    else $error("upper pins not given to segments");

  low_seg_a: assert property (
    @(posedge clk_i) disable iff (rst_i) functional && seg_sel_r[3:2] == 2'b01 && seg_sel_r != 4'h4
    |=> port_a_pin_oe_o == 8'hff)
    else $error("lower pins not given to segments");

  dir_write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr_lane0 ##1 a_dir_r != 8'h00);
  b_read_c: cover property (@(posedge clk_i) disable iff (rst_i) rd_b_data && b_dir_r != 8'h00);
  segment_c: cover property (@(posedge clk_i) disable iff (rst_i) functional && seg_sel_r == 4'h5);
  standby_c: cover property (@(posedge clk_i) disable iff (rst_i) mode_r == seg_io_pkg::MODE_STANDBY);
  a_read_c: cover property (@(posedge clk_i) disable iff (rst_i) rd_a_data && a_dir_r != 8'h00 && a_dir_r != 8'hff);

endmodule

`default_nettype wire

// *** src/seg_io_pkg.sv ***
package seg_io_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_PORT_A_DATA_LATCH = 16'hffda;
  localparam logic [15:0] IDX_PORT_B_DATA_LATCH = 16'hffdb;
  localparam logic [15:0] IDX_PORT_A_DIRECTION = 16'hffea;
  localparam logic [15:0] IDX_PORT_B_DIRECTION = 16'hffeb;
  localparam logic [15:0] IDX_LCD_PORT_CONTROL = 16'hffc0;
  localparam logic [15:0] IDX_OP_MODE = 16'hffc1;

  // field layout
  localparam int SEG_SEL_LSB = 0;
  localparam int SEG_SEL_W = 4;
  localparam int OP_MODE_LSB = 0;
  localparam int OP_MODE_W = 3;

  // reset and readback values
  localparam logic [7:0] DATA_LATCH_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [3:0] SEG_SEL_RST = 4'h0;
  localparam logic [7:0] DIRECTION_READ = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // segment-select codes, lower half of the first port
  localparam logic [3:0] SEG_SEL_LOW_GPIO_EXTRA = 4'h4;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_SUBACTIVE = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_SUBSLEEP = 3'b011,
    MODE_WATCH = 3'b100,
    MODE_STANDBY = 3'b101
  } op_mode_e;

  localparam op_mode_e OP_MODE_RST = MODE_ACTIVE;

endpackage

// *** tb/board_pins.sv ***
`timescale 1ns/10ps
`default_nettype none

// board side of one 8-pin port; released pins show what the board forces
module board_pins (
  input wire logic [7:0] drv_i, // level forced by the board on released pins
  input wire logic [7:0] o_i, // block drive value
  input wire logic [7:0] oe_i, // block drive enable
  output logic [7:0] lvl_o // resolved pin level
);
  always_comb begin
    lvl_o = (oe_i & o_i) | (~oe_i & drv_i);
  end
endmodule

`default_nettype wire

// *** tb/segment_shared_io_ports_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module segment_shared_io_ports_tb;
  localparam logic [15:0] AD = seg_io_pkg::IDX_PORT_A_DATA_LATCH;
  localparam logic [15:0] BD = seg_io_pkg::IDX_PORT_B_DATA_LATCH;
  localparam logic [15:0] AR = seg_io_pkg::IDX_PORT_A_DIRECTION;
  localparam logic [15:0] BR = seg_io_pkg::IDX_PORT_B_DIRECTION;
  localparam logic [15:0] LC = seg_io_pkg::IDX_LCD_PORT_CONTROL;
  localparam logic [15:0] OM = seg_io_pkg::IDX_OP_MODE;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [17:0] adr_i = 18'h00000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [7:0] lcd = 8'h00, ext_a = 8'h00, ext_b = 8'h00;
  logic [7:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  seg_io_pkg::op_mode_e md[5] = '{seg_io_pkg::MODE_SLEEP, seg_io_pkg::MODE_SUBSLEEP,
    seg_io_pkg::MODE_WATCH, seg_io_pkg::MODE_SUBACTIVE, seg_io_pkg::MODE_STANDBY};

  segment_shared_io_ports u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .lcd_segment_output_i(lcd), .port_a_pin_i(pa_i), .port_a_pin_o(pa_o), .port_a_pin_oe_o(pa_oe),
    .port_b_pin_i(pb_i), .port_b_pin_o(pb_o), .port_b_pin_oe_o(pb_oe));
  board_pins u_pa (.drv_i(ext_a), .o_i(pa_o), .oe_i(pa_oe), .lvl_o(pa_i));
  board_pins u_pb (.drv_i(ext_b), .o_i(pb_o), .oe_i(pb_oe), .lvl_o(pb_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD read data expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_pin(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // holds the request until ack is sampled high, then one idle cycle
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, idx, 8'h00);
  endtask

  // {oe, o} of the first port for a select code
  function automatic logic [15:0] pa_exp(input logic [3:0] s, input logic [7:0] d, input logic [7:0] l,
                                         input logic [7:0] g);
    logic [7:0] m;
    m = {{4{s[3:2] == 2'b00}}, {4{s[3:2] == 2'b00 || s == 4'h4}}};
    pa_exp = {(m & d) | ~m, (m & d & l) | (~m & g)};
  endfunction

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) cmp_rd(32'hffffffff, dat_o);
      else cmp_rd(exp_q.pop_front(), dat_o);
    end
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, l, e, last;
    logic [15:0] x;
    d = 8'($urandom(32'hf590));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ext_a <= 8'($urandom);
    ext_b <= 8'($urandom);
    @(posedge clk_i);
    cmp_pin("a oe", 8'h00, pa_oe);
    cmp_pin("b oe", 8'h00, pb_oe);
    rd(AD, ext_a);
    rd(BD, ext_b);
    rd(AR, 8'hff);
    rd(BR, 8'hff);
    rd(16'h0100, 8'h00);
    wb(1'b1, BR, 8'hff);
    wb(1'b1, AR, 8'hff);
    rd(BD, 8'h00);
    rd(AD, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      e = 8'($urandom);
      if (i[0]) ext_b <= e;
      else ext_a <= e;
      wb(1'b1, i[0] ? BR : AR, d);
      wb(1'b1, i[0] ? BD : AD, l);
      rd(i[0] ? BD : AD, (d & l) | (~d & e));
      cmp_pin("oe", d, i[0] ? pb_oe : pa_oe);
      cmp_pin("o", d & l, i[0] ? pb_o : pa_o);
    end
    $display("direction test done");
    // last loop pass set the second port; give the first port the same d and l
    wb(1'b1, AR, d);
    wb(1'b1, AD, l);
    for (int s = 0; s < 16; s++) begin
      lcd <= 8'($urandom);
      wb(1'b1, LC, 8'(s));
      x = pa_exp(4'(s), d, l, lcd);
      cmp_pin("a oe", x[15:8], pa_oe);
      cmp_pin("a o", x[7:0], pa_o);
    end
    $display("select test done");
    wb(1'b1, LC, 8'h00);
    wb(1'b1, AR, 8'hff);
    wb(1'b1, AD, 8'h5a);
    last = 8'h5a;
    for (int i = 0; i < 5; i++) begin
      l = 8'($urandom);
      wb(1'b1, OM, {5'h0, md[i]});
      wb(1'b1, AD, l);
      if (md[i] == seg_io_pkg::MODE_SUBACTIVE) last = l;
      cmp_pin("mode oe", md[i] == seg_io_pkg::MODE_STANDBY ? 8'h00 : 8'hff, pa_oe);
      cmp_pin("mode o", md[i] == seg_io_pkg::MODE_STANDBY ? 8'h00 : last, pa_o);
    end
    $display("mode test done");
    wb(1'b1, OM, 8'h00);
    wb(1'b1, OM, 8'h07);
    wb(1'b1, BR, 8'hff);
    cmp_pin("refused mode oe", 8'hff, pa_oe);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_pin("reset a oe", 8'h00, pa_oe);
    cmp_pin("reset b oe", 8'h00, pb_oe);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(AD, ext_a);
    wb(1'b1, BR, 8'hff);
    rd(BD, 8'h00);
    $display("second reset test done");
    repeat (3) @(posedge clk_i);
    cmp_pin("queue left", 8'h00, 8'(exp_q.size()));
    test_done();
  end
endmodule

`default_nettype wire
